//--- common/csi_pkg.sv
// constants, field positions and carrier types for the clocked serial / two-wire bus channel
// assumes one 40 MHz clock domain and an AXI4-Lite master with 32-bit data
package csi_pkg;

    // ==================== clock and timing ====================
    localparam int CLK_HZ = 40_000_000;
    localparam int PRESCALE_HZ = 2_500_000;
    localparam logic [7:0] PRESCALE_DIV = 8'(CLK_HZ / PRESCALE_HZ);

    // ==================== register map ====================
    // register index; byte address is four times the index
    localparam int ADDR_W = 18;
    localparam logic [15:0] IDX_MODE = 16'hff60;
    localparam logic [15:0] IDX_CTRL = 16'hff61;
    localparam logic [15:0] IDX_SHIFT = 16'hff62;
    localparam logic [15:0] IDX_SLAVE = 16'hff63;
    localparam logic [15:0] IDX_STATUS = 16'hff64;

    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [7:0] SLAVE_RST = 8'h00;

    // channel_mode_register fields
    localparam int MODE_EN = 7;
    localparam int MODE_MATCH = 6;
    localparam int MODE_WAKE = 5;
    localparam int MODE_M4 = 4;
    localparam int MODE_M3 = 3;
    localparam int MODE_ORDER = 2;
    localparam int MODE_CKHI = 1;
    localparam int MODE_CKLO = 0;

    // serial_bus_control fields
    localparam int CTRL_HI_LSB = 4;
    localparam int CTRL_CMDD = 3;
    localparam int CTRL_RELD = 2;
    localparam int CTRL_COMMAND_TRIGGER = 1;
    localparam int CTRL_RELEASE_TRIGGER = 0;

    // status fields
    localparam int STAT_IRQ = 0;
    localparam int STAT_BUSY = 1;
    localparam int STAT_SEL = 2;
    localparam int STAT_CLS_LSB = 3;
    localparam int STAT_PORT = 7;

    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic LATCH_RST = 1'b1;
    localparam logic PORT_RST = 1'b1;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ==================== types ====================
    typedef enum logic [1:0] {
        CLS_DATA = 2'b00,
        CLS_CMD = 2'b01,
        CLS_ADDR = 2'b11
    } byte_class_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SHIFT = 1'b1
    } xfer_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

endpackage

//--- design/pin_sync.sv
// two-flop synchroniser for the three pin inputs
// assumes pins are asynchronous to clk; first stage is read only by the second
`timescale 1ns/10ps
module pin_sync (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // pins
    input wire logic [2:0] pinIn,
    output logic [2:0] pinSync
);
    logic [2:0] stage1;

    always_ff @(posedge clk) begin
        if (srst) begin
            stage1 <= 3'h7;
            pinSync <= 3'h7;
        end else begin
            stage1 <= pinIn;
            pinSync <= stage1;
        end
    end
endmodule // pin_sync

//--- design/tick_divider.sv
// prescaler giving a one-cycle enable pulse every PRESCALE_DIV clocks
// assumes run is a level from the same clock domain
`timescale 1ns/10ps
module tick_divider import csi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // control
    input wire logic run,
    output logic tick
);
    logic [7:0] count;

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            count <= 8'h00;
            tick <= 1'b0;
        end else if (count == PRESCALE_DIV - 8'h01) begin
            count <= 8'h00;
            tick <= 1'b1;
        end else begin
            count <= count + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule // tick_divider

//--- design/clocked_serial_two_wire_bus.sv
// serial channel: three-wire clocked shifter and two-wire bus slave/master framing
// assumes an AXI4-Lite master on clk, pins asynchronous, timerTick a one-cycle enable on clk
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module clocked_serial_two_wire_bus import csi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register bus
    input axil_req_t axiReq,
    output axil_rsp_t axiRsp,
    // timer enable for clock select 2
    input wire logic timerTick,
    // pin a: serial_in or bus_data_a
    input wire logic dataAIn,
    output logic dataAOut,
    output logic dataAEnN,
    // pin b: serial_out or bus_data_b
    input wire logic dataBIn,
    output logic dataBOut,
    output logic dataBEnN,
    // serial_clock_pin
    input wire logic sckIn,
    output logic sckOut,
    output logic sckEnN,
    // channel_irq_flag
    output logic channelIrqFlag
);
    // ==================== registers and state ====================
    logic [7:0] modeReg;
    logic [3:0] ctrlHi;
    logic [7:0] shiftReg;
    logic [7:0] slaveAddr;
    logic outLatch;
    logic portLatch;
    logic relDetect;
    logic cmdDetect;
    logic addrMatch;
    logic selected;
    logic irqFlag;
    byte_class_t byteClass;
    xfer_state_t state;
    logic [2:0] bitCnt;
    logic sckInt;
    logic prevLvl;
    logic prevData;
    logic [2:0] pinSync;
    logic divTick;

    // bus slave state
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] awAddrQ;
    logic [7:0] wByteQ;
    logic wLaneQ;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;

    // ==================== decode ====================
    logic enable, wake, busMode, wireMode, internalClk, useLineA, lsbFirst;
    logic tick, serialLvl, dataLine, riseEdge, fallEdge, busy;
    logic relSeen, cmdSeen, done, start, match, isAddr;
    logic [7:0] newByte, wrRev, rdRev;

    assign enable = modeReg[MODE_EN];
    assign wake = modeReg[MODE_WAKE];
    assign wireMode = !modeReg[MODE_M4];
    assign busMode = modeReg[MODE_M4] && !modeReg[MODE_M3];
    assign internalClk = modeReg[MODE_CKHI];
    assign useLineA = modeReg[MODE_ORDER];
    assign lsbFirst = wireMode && modeReg[MODE_ORDER];
    assign busy = (state == ST_SHIFT);
    assign tick = modeReg[MODE_CKLO] ? divTick : timerTick;

    pin_sync u_sync (
        .clk(clk),
        .srst(srst),
        .pinIn({sckIn, dataBIn, dataAIn}),
        .pinSync(pinSync)
    );

    tick_divider u_div (
        .clk(clk),
        .srst(srst),
        .run(busy && internalClk && modeReg[MODE_CKLO]),
        .tick(divTick)
    );

    // external clock only after synchronising; internal clock is our own flop
    assign serialLvl = internalClk ? sckInt : pinSync[2];
    assign dataLine = (busMode && !useLineA) ? pinSync[1] : pinSync[0];
    assign riseEdge = !prevLvl && serialLvl;
    assign fallEdge = prevLvl && !serialLvl;

    // conditions only while clock is high and no byte is clocking
    assign relSeen = busMode && enable && !busy && serialLvl && prevLvl && !prevData && dataLine;
    assign cmdSeen = busMode && enable && !busy && serialLvl && prevLvl && prevData && !dataLine;

    assign newByte = {shiftReg[6:0], dataLine};
    assign done = busy && riseEdge && (bitCnt == LAST_BIT);
    assign match = (newByte == slaveAddr);
    assign isAddr = (byteClass == CLS_ADDR);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_rev
            assign wrRev[gi] = wByteQ[7-gi];
            assign rdRev[gi] = shiftReg[7-gi];
        end
    endgenerate

    // ==================== register bus ====================
    logic doWrite, wrOk;
    logic [15:0] wrIdx, rdIdx;
    logic wrMode, wrCtrl, wrShift, wrSlave, wrStatus;

    assign doWrite = awHeld && wHeld && !bvalid;
    assign wrIdx = awAddrQ[ADDR_W-1:2];
    assign rdIdx = axiReq.araddr[ADDR_W-1:2];
    assign wrMode = doWrite && wLaneQ && (wrIdx == IDX_MODE);
    assign wrCtrl = doWrite && wLaneQ && (wrIdx == IDX_CTRL);
    assign wrShift = doWrite && wLaneQ && (wrIdx == IDX_SHIFT);
    assign wrSlave = doWrite && wLaneQ && (wrIdx == IDX_SLAVE);
    assign wrStatus = doWrite && wLaneQ && (wrIdx == IDX_STATUS);
    assign wrOk = (wrIdx == IDX_MODE) || (wrIdx == IDX_CTRL) || (wrIdx == IDX_SHIFT)
        || (wrIdx == IDX_SLAVE) || (wrIdx == IDX_STATUS);
    // a load is accepted only while idle; starting also needs enable already set
    assign start = wrShift && !busy && enable && (internalClk || serialLvl);

    assign axiRsp.awready = !awHeld && !bvalid;
    assign axiRsp.wready = !wHeld && !bvalid;
    assign axiRsp.bvalid = bvalid;
    assign axiRsp.bresp = bresp;
    assign axiRsp.arready = !rvalid;
    assign axiRsp.rvalid = rvalid;
    assign axiRsp.rresp = rresp;
    assign axiRsp.rdata = rdata;

    always_ff @(posedge clk) begin
        if (srst) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrQ <= '0;
            wByteQ <= 8'h00;
            wLaneQ <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else begin
            if (axiReq.awvalid && !awHeld && !bvalid) begin
                awHeld <= 1'b1;
                awAddrQ <= axiReq.awaddr;
            end
            if (axiReq.wvalid && !wHeld && !bvalid) begin
                wHeld <= 1'b1;
                wByteQ <= axiReq.wdata[7:0];
                wLaneQ <= axiReq.wstrb[0];
            end
            if (doWrite) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid && axiReq.bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else if (axiReq.arvalid && !rvalid) begin
            rvalid <= 1'b1;
            rresp <= RESP_OKAY;
            unique case (rdIdx)
                IDX_MODE: rdata <= {24'h00_0000, modeReg[7], addrMatch, modeReg[5:0]};
                IDX_CTRL: rdata <= {24'h00_0000, ctrlHi, cmdDetect, relDetect, 2'b00};
                IDX_SHIFT: rdata <= {24'h00_0000, lsbFirst ? rdRev : shiftReg};
                IDX_SLAVE: rdata <= {24'h00_0000, slaveAddr};
                IDX_STATUS: rdata <= {24'h00_0000, portLatch, 2'b00, byteClass, selected, busy, irqFlag};
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid && axiReq.rready) begin
            rvalid <= 1'b0;
        end
    end

    // ==================== software registers ====================
    always_ff @(posedge clk) begin
        if (srst) begin
            modeReg <= MODE_RST;
            ctrlHi <= CTRL_RST[7:4];
            slaveAddr <= SLAVE_RST;
            portLatch <= PORT_RST;
        end else begin
            if (wrMode) modeReg <= {wByteQ[7], 1'b0, wByteQ[5:0]};
            if (wrCtrl) ctrlHi <= wByteQ[7:CTRL_HI_LSB];
            if (wrSlave) slaveAddr <= wByteQ;
            if (wrStatus) portLatch <= wByteQ[STAT_PORT];
        end
    end

    // ==================== transfer sequencing ====================
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            state <= ST_IDLE;
            bitCnt <= 3'h0;
        end else if (start) begin
            state <= ST_SHIFT;
            bitCnt <= 3'h0;
        end else if (busy && riseEdge) begin
            bitCnt <= bitCnt + 3'h1;
            if (bitCnt == LAST_BIT) state <= ST_IDLE;
        end
    end

    // internal clock rests high so the first edge of a byte is a fall
    always_ff @(posedge clk) begin
        if (srst || !busy || !internalClk) sckInt <= 1'b1;
        else if (tick) sckInt <= !sckInt;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            prevLvl <= 1'b1;
            prevData <= 1'b1;
        end else begin
            prevLvl <= serialLvl;
            prevData <= dataLine;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) shiftReg <= SHIFT_RST;
        else if (wrShift && !busy) shiftReg <= lsbFirst ? wrRev : wByteQ;
        else if (busy && riseEdge) shiftReg <= newByte;
    end

    // triggers act only while enabled and are never stored, so they read back zero
    always_ff @(posedge clk) begin
        if (srst) outLatch <= LATCH_RST;
        else if (busy && fallEdge) outLatch <= shiftReg[7];
        else if (wrCtrl && enable && wByteQ[CTRL_RELEASE_TRIGGER]) outLatch <= 1'b1;
        else if (wrCtrl && enable && wByteQ[CTRL_COMMAND_TRIGGER]) outLatch <= 1'b0;
    end

    // ==================== bus framing ====================
    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            relDetect <= 1'b0;
            cmdDetect <= 1'b0;
        end else begin
            if (start) begin
                relDetect <= 1'b0;
                cmdDetect <= 1'b0;
            end
            if (done && isAddr && wake && !match) relDetect <= 1'b0;
            if (relSeen) begin
                relDetect <= 1'b1;
                cmdDetect <= 1'b0;
            end
            if (cmdSeen) cmdDetect <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) byteClass <= CLS_DATA;
        else if (start) begin
            if (busMode && relDetect && cmdDetect) byteClass <= CLS_ADDR;
            else if (busMode && cmdDetect) byteClass <= CLS_CMD;
            else byteClass <= CLS_DATA;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !enable) begin
            selected <= 1'b0;
            addrMatch <= 1'b0;
        end else begin
            if (relSeen) selected <= 1'b0;
            else if (done && isAddr && match) selected <= 1'b1;
            if (done && isAddr) addrMatch <= match;
        end
    end

    // set beats a software clear in the same cycle
    always_ff @(posedge clk) begin
        if (srst) irqFlag <= 1'b0;
        else if (done && (!wake || (isAddr && match))) irqFlag <= 1'b1;
        else if (wrStatus && wByteQ[STAT_IRQ]) irqFlag <= 1'b0;
    end
    assign channelIrqFlag = irqFlag;

    // ==================== pins ====================
    // open drain lines only ever pull low; the pull-up makes the high
    always_comb begin
        dataAOut = 1'b0;
        dataAEnN = 1'b1;
        dataBOut = 1'b0;
        dataBEnN = 1'b1;
        if (enable && busMode && useLineA) dataAEnN = outLatch;
        if (enable && busMode && !useLineA) dataBEnN = outLatch;
        if (enable && wireMode) begin
            dataBOut = outLatch;
            dataBEnN = 1'b0;
        end
    end

    assign sckEnN = !(enable && internalClk);
    assign sckOut = busy ? sckInt : portLatch;

endmodule // clocked_serial_two_wire_bus

//--- verif/csi_bus_sva.sv
// concurrent checks on the serial channel, seen from its top-level ports only
// assumes one clk domain, srst synchronous active high, aw and w offered together
`timescale 1ns/10ps
module csi_bus_sva import csi_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // register bus
    input axil_req_t axiReq,
    input axil_rsp_t axiRsp,
    // pins
    input wire logic timerTick,
    input wire logic dataAIn,
    input wire logic dataAOut,
    input wire logic dataAEnN,
    input wire logic dataBIn,
    input wire logic dataBOut,
    input wire logic dataBEnN,
    input wire logic sckIn,
    input wire logic sckOut,
    input wire logic sckEnN,
    input wire logic channelIrqFlag
);
    logic wrEvQ;
    logic [15:0] addrQ;
    logic [7:0] dataQ;
    logic [7:0] modeQ;
    logic [3:0] riseCnt;
    wire wrEv = axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready && axiReq.wstrb[0];
    wire arOk = axiReq.araddr[17:2] inside {[IDX_MODE:IDX_STATUS]};

    // ==========================================
    // write shadow, lands on the same edge as the design's own write
    always_ff @(posedge clk) begin
        wrEvQ <= wrEv && !srst;
        addrQ <= axiReq.awaddr[17:2];
        dataQ <= axiReq.wdata[7:0];
    end
    always_ff @(posedge clk) begin
        if (srst) modeQ <= 8'h00;
        else if (wrEvQ && addrQ == IDX_MODE) modeQ <= dataQ;
    end
    // saturating count of driven clock rises since the last shift write
    always_ff @(posedge clk) begin
        if (srst) riseCnt <= 4'h0;
        else if (wrEvQ && addrQ == IDX_SHIFT) riseCnt <= 4'h0;
        else if ($rose(sckOut) && !sckEnN && riseCnt != 4'hf) riseCnt <= riseCnt + 4'h1;
    end

    // ==========================================
    default clocking dcb @(posedge clk); endclocking
    default disable iff (srst);

    rst_state_a: assert property ($fell(srst) |-> sckOut && dataAEnN && dataBEnN && sckEnN && !channelIrqFlag)
        else $error("pin state after reset wrong");
    wr_answer_a: assert property (wrEv |-> ##2 axiRsp.bvalid)
        else $error("write response late");
    unmapped_rd_a: assert property (axiReq.arvalid && !axiRsp.rvalid && !arOk
        |=> axiRsp.rvalid && axiRsp.rresp == RESP_SLVERR && axiRsp.rdata == 32'h0)
        else $error("unmapped read not refused");
    rel_trig_a: assert property (wrEvQ && addrQ == IDX_CTRL && dataQ[0] && modeQ[7] && !modeQ[4]
        |-> ##[1:2] dataBOut)
        else $error("release trigger did not set latch");
    cmd_trig_a: assert property (wrEvQ && addrQ == IDX_CTRL && dataQ[1:0] == 2'b10 && modeQ[7] && !modeQ[4]
        |-> ##[1:2] !dataBOut)
        else $error("command trigger did not clear latch");
    open_drain_a: assert property (modeQ[7] && modeQ[4:3] == 2'b10
        |-> (dataAEnN || !dataAOut) && (dataBEnN || !dataBOut))
        else $error("bus line driven high");
    sck_dir_a: assert property (modeQ[4:3] != 2'b11 |-> sckEnN == !(modeQ[7] && modeQ[1]))
        else $error("clock pin direction wrong");
    eight_bits_a: assert property (!sckEnN |-> riseCnt <= 4'd8)
        else $error("more than eight clocks");
    irq_count_a: assert property ($rose(channelIrqFlag) && !sckEnN |-> ##[0:2] riseCnt == 4'd8)
        else $error("flag not after eighth clock");
    no_start_a: assert property (!modeQ[7] |-> !$rose(channelIrqFlag))
        else $error("transfer while disabled");

    cover property ($rose(channelIrqFlag) && !sckEnN);
    cover property ($rose(channelIrqFlag) && sckEnN);
    cover property (wrEvQ && addrQ == IDX_CTRL);
endmodule // csi_bus_sva

//--- verif/serial_peer.sv
// far side: a three-wire peer while lead is low, the bus master while high
// assumes the bench resolves wire levels; bus tasks are paced on clk
`timescale 1ns/10ps
module serial_peer (
    // pacing
    input wire logic clk,
    input wire logic lead,
    // wires
    input wire logic sckLine,
    input wire logic lineB,
    output logic peerA,
    output logic peerSck
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    initial begin
        peerA = 1'b1;
        peerSck = 1'b1;
    end

    // ==========================================
    // refill with a changing pattern so a stale bit is never mistaken for data
    always @(negedge sckLine) begin
        if (!lead) begin
            peerA <= tx[7];
            tx <= {tx[6:0], ~tx[7]};
        end
    end
    always @(posedge sckLine) begin
        if (!lead) rx <= {rx[6:0], lineB};
    end

    // ==========================================
    task automatic hold;
        repeat (16) @(posedge clk);
    endtask
    task automatic bus_release_condition;
        peerSck <= 1'b0;
        hold();
        peerA <= 1'b0;
        hold();
        peerSck <= 1'b1;
        hold();
        peerA <= 1'b1;
        hold();
    endtask
    task automatic cmd;
        peerSck <= 1'b0;
        hold();
        peerA <= 1'b1;
        hold();
        peerSck <= 1'b1;
        hold();
        peerA <= 1'b0;
        hold();
    endtask
    // clock runs only for the byte, then rests high
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            peerSck <= 1'b0;
            peerA <= b[i];
            hold();
            peerSck <= 1'b1;
            hold();
        end
    endtask
endmodule // serial_peer

//--- verif/test_clocked_serial_two_wire_bus.sv
// self-checking bench: register tasks over the bus, a far-side peer on the pins
// assumes csi_bus_sva and serial_peer are compiled before this file
`timescale 1ns/10ps
module test_clocked_serial_two_wire_bus import csi_pkg::*;;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic timerTick = 1'b0;
    logic lead = 1'b0;
    axil_req_t axiReq = '0;
    axil_rsp_t axiRsp;
    logic dataAOut, dataAEnN, dataBOut, dataBEnN, sckOut, sckEnN, channelIrqFlag, peerA, peerSck;
    // pull-ups on both data lines; only line a is also wired-and with the peer
    wire lineA = (dataAEnN | dataAOut) & peerA;
    wire lineB = dataBEnN | dataBOut;
    wire sckLine = sckEnN ? peerSck : sckOut;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [7:0] v;

    clocked_serial_two_wire_bus u_clocked_serial_two_wire_bus (.clk(clk), .srst(srst), .axiReq(axiReq),
        .axiRsp(axiRsp), .timerTick(timerTick), .dataAIn(lineA), .dataAOut(dataAOut), .dataAEnN(dataAEnN),
        .dataBIn(lineB), .dataBOut(dataBOut), .dataBEnN(dataBEnN), .sckIn(sckLine), .sckOut(sckOut),
        .sckEnN(sckEnN), .channelIrqFlag(channelIrqFlag));
    serial_peer u_serial_peer (.clk(clk), .lead(lead), .sckLine(sckLine), .lineB(lineB), .peerA(peerA),
        .peerSck(peerSck));

    // ==========================================
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        timerTick <= (cyc % 4 == 3);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    // ==========================================
    task automatic report_and_stop;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask
    // responses read right at the edge, before the design's flops move on
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        @(posedge clk);
        axiReq.awaddr <= {i, 2'b00};
        axiReq.wdata <= {24'h0, d};
        axiReq.wstrb <= 4'h1;
        axiReq.awvalid <= 1'b1;
        axiReq.wvalid <= 1'b1;
        axiReq.bready <= 1'b1;
        do begin
            @(posedge clk);
            if (axiRsp.awready) axiReq.awvalid <= 1'b0;
            if (axiRsp.wready) axiReq.wvalid <= 1'b0;
        end while (!axiRsp.bvalid);
        axiReq.bready <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] i, output logic [7:0] d);
        @(posedge clk);
        axiReq.araddr <= {i, 2'b00};
        axiReq.arvalid <= 1'b1;
        axiReq.rready <= 1'b1;
        do begin
            @(posedge clk);
            if (axiRsp.arready) axiReq.arvalid <= 1'b0;
        end while (!axiRsp.rvalid);
        d = axiRsp.rdata[7:0];
        axiReq.rready <= 1'b0;
    endtask
    task automatic rc(input logic [15:0] i, input logic [7:0] e, input string n);
        rd(i, v);
        chk(n, e, v);
    endtask
    task automatic await_idle;
        do rd(IDX_STATUS, v);
        while (v[STAT_BUSY]);
    endtask

    // ==========================================
    initial begin
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        rc(IDX_CTRL, 8'h00, "ctrl reset");
        rc(IDX_MODE, 8'h00, "mode reset");
        rd(16'hff6f, v);
        chk("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, axiRsp.rresp});
        wr(IDX_MODE, 8'h83);
        wr(IDX_CTRL, 8'h02);
        chk("latch cleared", 8'h00, {7'h0, dataBOut});
        rc(IDX_CTRL, 8'h00, "triggers self clear");
        wr(IDX_CTRL, 8'h01);
        chk("latch set", 8'h01, {7'h0, dataBOut});
        u_serial_peer.tx = 8'h3c;
        wr(IDX_SHIFT, 8'ha5);
        await_idle();
        chk("msb sent", 8'ha5, u_serial_peer.rx);
        rc(IDX_SHIFT, 8'h3c, "msb received");
        rc(IDX_STATUS, 8'h81, "flag after byte");
        wr(IDX_STATUS, 8'h81);
        rc(IDX_STATUS, 8'h80, "flag cleared");
        // lsb first on the timer clock
        wr(IDX_MODE, 8'h86);
        u_serial_peer.tx = 8'h01;
        wr(IDX_SHIFT, 8'h01);
        await_idle();
        chk("lsb sent", 8'h80, u_serial_peer.rx);
        rc(IDX_SHIFT, 8'h80, "lsb received");
        wr(IDX_STATUS, 8'h81);
        wr(IDX_MODE, 8'h06);
        wr(IDX_SHIFT, 8'h55);
        wr(IDX_MODE, 8'h86);
        rc(IDX_STATUS, 8'h80, "late enable");
        // bus mode on line a, peer leads with external clock
        lead = 1'b1;
        wr(IDX_SLAVE, 8'h5a);
        rc(IDX_SLAVE, 8'h5a, "slave address");
        wr(IDX_MODE, 8'h94);
        wr(IDX_CTRL, 8'h01);
        u_serial_peer.bus_release_condition();
        u_serial_peer.cmd();
        rc(IDX_CTRL, 8'h0c, "conditions seen");
        wr(IDX_SHIFT, 8'hff);
        u_serial_peer.send(8'h5a);
        await_idle();
        rc(IDX_STATUS, 8'h9d, "address hit");
        rc(IDX_MODE, 8'hd4, "match flag");
        wr(IDX_STATUS, 8'h81);
        u_serial_peer.cmd();
        wr(IDX_SHIFT, 8'hff);
        u_serial_peer.send(8'h11);
        await_idle();
        rc(IDX_STATUS, 8'h8d, "command byte");
        wr(IDX_STATUS, 8'h81);
        wr(IDX_SHIFT, 8'hff);
        u_serial_peer.send(8'h22);
        await_idle();
        rc(IDX_STATUS, 8'h85, "data byte");
        wr(IDX_STATUS, 8'h81);
        u_serial_peer.bus_release_condition();
        rc(IDX_STATUS, 8'h80, "deselected");
        wr(IDX_MODE, 8'hb4);
        u_serial_peer.cmd();
        wr(IDX_SHIFT, 8'hff);
        u_serial_peer.send(8'h33);
        await_idle();
        rc(IDX_STATUS, 8'h98, "wake miss");
        u_serial_peer.bus_release_condition();
        u_serial_peer.cmd();
        wr(IDX_SHIFT, 8'hff);
        u_serial_peer.send(8'h5a);
        await_idle();
        rc(IDX_STATUS, 8'h9d, "wake hit");
        report_and_stop();
    end
endmodule // test_clocked_serial_two_wire_bus

bind clocked_serial_two_wire_bus csi_bus_sva u_csi_bus_sva (.clk(clk), .srst(srst), .axiReq(axiReq),
    .axiRsp(axiRsp), .timerTick(timerTick), .dataAIn(dataAIn), .dataAOut(dataAOut), .dataAEnN(dataAEnN),
    .dataBIn(dataBIn), .dataBOut(dataBOut), .dataBEnN(dataBEnN), .sckIn(sckIn), .sckOut(sckOut),
    .sckEnN(sckEnN), .channelIrqFlag(channelIrqFlag));
